// ==== hdl/bca_core.sv ====
// Execute slice: increment, increment-skip, OR, moves, literal load, no-op
`timescale 1ns/1ns
`default_nettype none
`include "bca_cfg.svh"

module bca_core
    import bca_pkg::*;
#(
    parameter int ADDR_W = 5,
    parameter int PC_W   = 11
) (
    input  wire logic              i_mclk,
    input  wire logic              i_resetn,
    input  wire logic              i_instr_valid,
    input  wire logic [11:0]       i_instr,
    input  wire logic [7:0]        i_file_rdata,
    output logic [ADDR_W-1:0]      o_file_raddr,
    output bca_file_wr_t           o_file_wr,
    output logic [7:0]             o_acc,
    output logic                   o_zero,
    output logic [PC_W-1:0]        o_pc,
    output logic                   o_squash,
    output logic                   o_unsupported
);

    // Anything unmatched falls to other and runs as a no-op
    function automatic bca_op_t decode(input logic [11:0] ins);
        bca_op_t op;
        op = BCA_OP_OTHER;
        if (ins == `BCA_OPC_NOP) begin
            op = BCA_OP_NOP;
        end else if ((ins & `BCA_OPC_COPY_MASK) == `BCA_OPC_COPY) begin
            op = BCA_OP_COPY;
        end else if ((ins & `BCA_OPC_DF_MASK) == `BCA_OPC_OR_REG) begin
            op = BCA_OP_OR_REG;
        end else if ((ins & `BCA_OPC_DF_MASK) == `BCA_OPC_MOVE_REG) begin
            op = BCA_OP_MOVE_REG;
        end else if ((ins & `BCA_OPC_DF_MASK) == `BCA_OPC_INC_REG) begin
            op = BCA_OP_INC_REG;
        end else if ((ins & `BCA_OPC_DF_MASK) == `BCA_OPC_INC_SKIP) begin
            op = BCA_OP_INC_SKIP;
        end else if ((ins & `BCA_OPC_LIT_MASK) == `BCA_OPC_OR_LIT) begin
            op = BCA_OP_OR_LIT;
        end else if ((ins & `BCA_OPC_LIT_MASK) == `BCA_OPC_LOAD_LIT) begin
            op = BCA_OP_LOAD_LIT;
        end
        return op;
    endfunction : decode

    // Shared by the zero flag and the skip test so both agree on zero
    function automatic logic is_null(input logic [7:0] val);
        return (val == 8'h00);
    endfunction : is_null

    function automatic logic [7:0] incr8(input logic [7:0] val);
        // Wraps from all ones to zero, which the skip test relies on
        return val + 8'h01;
    endfunction : incr8

    function automatic logic [ADDR_W-1:0] addr_field(input logic [11:0] ins);
        return ins[ADDR_W-1:0];
    endfunction : addr_field

    function automatic logic [7:0] lit_field(input logic [11:0] ins);
        return ins[`BCA_LIT_MSB:0];
    endfunction : lit_field

    logic [7:0]        acc_reg;
    logic              zero_reg;
    logic [PC_W-1:0]   pc_reg;
    bca_state_t        state_reg;
    bca_file_wr_t      wr_reg;
    logic              unsup_reg;

    bca_op_t           op;
    logic              dest_file;
    logic [7:0]        lit;
    logic [7:0]        inc_val;
    logic [7:0]        result;
    logic              wr_acc;
    logic              wr_file;
    logic              upd_zero;
    logic              skip_req;
    logic              file_we;
    logic              exec;

    // A squashed slot still consumes the incoming word but executes nothing
    assign exec      = i_instr_valid && (state_reg == BCA_ST_RUN);
    assign file_we   = exec && wr_file;
    assign op        = decode(i_instr);
    assign dest_file = i_instr[`BCA_DEST_BIT];
    assign lit       = lit_field(i_instr);
    assign inc_val   = incr8(i_file_rdata);
    assign o_file_raddr = addr_field(i_instr);

    // Result path: what each operation would write, whether or not it lands
    always_comb begin
        result = 8'h00;
        case (op)
            BCA_OP_INC_REG: begin
                result = inc_val;
            end
            BCA_OP_INC_SKIP: begin
                result = inc_val;
            end
            BCA_OP_OR_LIT: begin
                result = acc_reg | lit;
            end
            BCA_OP_OR_REG: begin
                result = acc_reg | i_file_rdata;
            end
            BCA_OP_COPY: begin
                result = acc_reg;
            end
            BCA_OP_MOVE_REG: begin
                result = i_file_rdata;
            end
            BCA_OP_LOAD_LIT: begin
                result = lit;
            end
            BCA_OP_NOP: begin
                result = 8'h00;
            end
            default: begin
                result = 8'h00;
            end
        endcase
    end

    // Destination routing: the dest bit only matters for file-register forms
    always_comb begin
        wr_acc  = 1'b0;
        wr_file = 1'b0;
        case (op)
            BCA_OP_INC_REG: begin
                wr_acc  = !dest_file;
                wr_file = dest_file;
            end
            BCA_OP_INC_SKIP: begin
                wr_acc  = !dest_file;
                wr_file = dest_file;
            end
            BCA_OP_OR_LIT: begin
                wr_acc  = 1'b1;
                wr_file = 1'b0;
            end
            BCA_OP_OR_REG: begin
                wr_acc  = !dest_file;
                wr_file = dest_file;
            end
            BCA_OP_COPY: begin
                wr_acc  = 1'b0;
                wr_file = 1'b1;
            end
            BCA_OP_MOVE_REG: begin
                // Dest one rewrites the same value; only zero shows
                wr_acc  = !dest_file;
                wr_file = dest_file;
            end
            BCA_OP_LOAD_LIT: begin
                wr_acc  = 1'b1;
                wr_file = 1'b0;
            end
            BCA_OP_NOP: begin
                wr_acc  = 1'b0;
                wr_file = 1'b0;
            end
            default: begin
                wr_acc  = 1'b0;
                wr_file = 1'b0;
            end
        endcase
    end

    // Flag policy: skip forms, copies and literal loads leave the flag alone
    always_comb begin
        upd_zero = 1'b0;
        skip_req = 1'b0;
        case (op)
            BCA_OP_INC_REG: begin
                upd_zero = 1'b1;
                skip_req = 1'b0;
            end
            BCA_OP_INC_SKIP: begin
                upd_zero = 1'b0;
                skip_req = is_null(inc_val);
            end
            BCA_OP_OR_LIT: begin
                upd_zero = 1'b1;
                skip_req = 1'b0;
            end
            BCA_OP_OR_REG: begin
                upd_zero = 1'b1;
                skip_req = 1'b0;
            end
            BCA_OP_COPY: begin
                upd_zero = 1'b0;
                skip_req = 1'b0;
            end
            BCA_OP_MOVE_REG: begin
                upd_zero = 1'b1;
                skip_req = 1'b0;
            end
            BCA_OP_LOAD_LIT: begin
                upd_zero = 1'b0;
                skip_req = 1'b0;
            end
            BCA_OP_NOP: begin
                upd_zero = 1'b0;
                skip_req = 1'b0;
            end
            default: begin
                upd_zero = 1'b0;
                skip_req = 1'b0;
            end
        endcase
    end

    // Invalid cycles freeze the accumulator, flag, state and count, so the fetch side may stall freely
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            acc_reg <= `BCA_ACC_RESET;
        end else if (exec && wr_acc) begin
            acc_reg <= result;
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            zero_reg <= `BCA_ZERO_RESET;
        end else if (exec && upd_zero) begin
            zero_reg <= is_null(result);
        end
    end

    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_reg <= '0;
        end else begin
            wr_reg.we   <= file_we;
            wr_reg.addr <= addr_field(i_instr);
            wr_reg.data <= result;
        end
    end

    // Skip state turns the next slot into a no-op, giving two cycles
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= BCA_ST_RUN;
        end else if (i_instr_valid) begin
            case (state_reg)
                BCA_ST_RUN: begin
                    state_reg <= skip_req ? BCA_ST_SKIP : BCA_ST_RUN;
                end
                BCA_ST_SKIP: begin
                    state_reg <= BCA_ST_RUN;
                end
                default: begin
                    state_reg <= BCA_ST_RUN;
                end
            endcase
        end
    end

    // Squashed slots advance the count too, as their word was fetched
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            pc_reg <= `BCA_PC_RESET;
        end else if (i_instr_valid) begin
            pc_reg <= pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
        end
    end

    // Words outside this slice run as no-ops; the pulse lets the core trap them
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            unsup_reg <= 1'b0;
        end else begin
            unsup_reg <= exec && (op == BCA_OP_OTHER);
        end
    end

    assign o_acc         = acc_reg;
    assign o_zero        = zero_reg;
    assign o_pc          = pc_reg;
    assign o_file_wr     = wr_reg;
    assign o_squash      = (state_reg == BCA_ST_SKIP);
    assign o_unsupported = unsup_reg;

endmodule : bca_core
`default_nettype wire

// ==== hdl/bca_cfg.svh ====
// Encodings, field positions and reset values of the execute slice
`ifndef BCA_CFG_SVH
`define BCA_CFG_SVH
`define BCA_OPC_NOP          12'h000
`define BCA_OPC_COPY_MASK    12'hFE0
`define BCA_OPC_COPY         12'h020
`define BCA_OPC_DF_MASK      12'hFC0
`define BCA_OPC_OR_REG       12'h100
`define BCA_OPC_MOVE_REG     12'h200
`define BCA_OPC_INC_REG      12'h280
`define BCA_OPC_INC_SKIP     12'h3C0
`define BCA_OPC_LIT_MASK     12'hF00
`define BCA_OPC_OR_LIT       12'hD00
`define BCA_OPC_LOAD_LIT     12'hC00
`define BCA_DEST_BIT         5
`define BCA_LIT_MSB          7
`define BCA_ACC_RESET        8'h00
`define BCA_ZERO_RESET       1'b0
`define BCA_PC_RESET         11'h000
`endif

// ==== hdl/bca_pkg.sv ====
// Types shared by the execute slice
package bca_pkg;
    typedef enum logic [3:0] {
        BCA_OP_NOP      = 4'b0000,
        BCA_OP_INC_REG  = 4'b0001,
        BCA_OP_INC_SKIP = 4'b0010,
        BCA_OP_OR_LIT   = 4'b0011,
        BCA_OP_OR_REG   = 4'b0100,
        BCA_OP_COPY     = 4'b0101,
        BCA_OP_MOVE_REG = 4'b0110,
        BCA_OP_LOAD_LIT = 4'b0111,
        BCA_OP_OTHER    = 4'b1000
    } bca_op_t;

    typedef enum logic [0:0] {
        BCA_ST_RUN  = 1'b0,
        BCA_ST_SKIP = 1'b1
    } bca_state_t;

    typedef struct packed {
        logic       we;
        logic [4:0] addr;
        logic [7:0] data;
    } bca_file_wr_t;
endpackage : bca_pkg

// ==== testbench/bca_core_checker.sv ====
// Port assertions for the execute slice
`timescale 1ns/1ns
`default_nettype none
`include "bca_cfg.svh"
module bca_core_checker
    import bca_pkg::*;
#(
    parameter int ADDR_W = 5,
    parameter int PC_W   = 11
) (
    input wire logic              i_mclk,
    input wire logic              i_resetn,
    input wire logic              i_instr_valid,
    input wire logic [11:0]       i_instr,
    input wire logic [7:0]        i_file_rdata,
    input wire logic [ADDR_W-1:0] o_file_raddr,
    input wire bca_file_wr_t      o_file_wr,
    input wire logic [7:0]        o_acc,
    input wire logic              o_zero,
    input wire logic [PC_W-1:0]   o_pc,
    input wire logic              o_squash,
    input wire logic              o_unsupported
);
    wire        ex = i_instr_valid && !o_squash;
    wire [11:0] df = i_instr & `BCA_OPC_DF_MASK;
    wire [11:0] lt = i_instr & `BCA_OPC_LIT_MASK;
    wire        d  = i_instr[`BCA_DEST_BIT];
    wire        known = i_instr == `BCA_OPC_NOP || (i_instr & `BCA_OPC_COPY_MASK) == `BCA_OPC_COPY
        || df == `BCA_OPC_OR_REG || df == `BCA_OPC_MOVE_REG || df == `BCA_OPC_INC_REG
        || df == `BCA_OPC_INC_SKIP || lt == `BCA_OPC_OR_LIT || lt == `BCA_OPC_LOAD_LIT;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    sequence s_wrap; ex && df == `BCA_OPC_INC_SKIP && !d && i_file_rdata == 8'hff; endsequence
    sequence s_slot; i_instr_valid && o_squash; endsequence
    property p_inc; ex && df == `BCA_OPC_INC_REG && !d |=>
        o_acc == 8'($past(i_file_rdata) + 8'h01) && o_zero == ($past(i_file_rdata) == 8'hff); endproperty
    a_inc: assert property (p_inc) else $error("increment result wrong");
    property p_skip; s_wrap |=> o_squash && $stable(o_zero) && o_acc == 8'h00; endproperty
    a_skip: assert property (p_skip) else $error("skip on zero wrong");
    property p_slot; s_slot |=> !o_squash && $stable(o_acc) && $stable(o_zero) && !o_file_wr.we; endproperty
    a_slot: assert property (p_slot) else $error("squashed slot executed");
    property p_orl; ex && lt == `BCA_OPC_OR_LIT |=>
        o_acc == ($past(o_acc) | $past(i_instr[7:0])) && o_zero == (o_acc == 8'h00); endproperty
    a_orl: assert property (p_orl) else $error("or literal wrong");
    property p_orr; ex && df == `BCA_OPC_OR_REG |=> o_zero == (($past(o_acc) | $past(i_file_rdata)) == 8'h00); endproperty
    a_orr: assert property (p_orr) else $error("or register zero wrong");
    property p_copy; ex && (i_instr & `BCA_OPC_COPY_MASK) == `BCA_OPC_COPY |=>
        o_file_wr == {1'b1, $past(i_instr[4:0]), $past(o_acc)} && $stable(o_zero); endproperty
    a_copy: assert property (p_copy) else $error("copy write wrong");
    property p_move; ex && df == `BCA_OPC_MOVE_REG && d |=> o_file_wr.data == $past(i_file_rdata)
        && o_zero == ($past(i_file_rdata) == 8'h00) && $stable(o_acc); endproperty
    a_move: assert property (p_move) else $error("move test wrong");
    property p_load; ex && lt == `BCA_OPC_LOAD_LIT |=> o_acc == $past(i_instr[7:0]) && $stable(o_zero); endproperty
    a_load: assert property (p_load) else $error("load literal wrong");
    property p_nop; ex && i_instr == `BCA_OPC_NOP |=>
        $stable(o_acc) && $stable(o_zero) && !o_file_wr.we && o_pc == $past(o_pc) + 1'b1; endproperty
    a_nop: assert property (p_nop) else $error("no-op changed state");
    property p_mova; ex && df == `BCA_OPC_MOVE_REG && !d |=> o_acc == $past(i_file_rdata)
        && o_zero == ($past(i_file_rdata) == 8'h00) && !o_file_wr.we; endproperty
    a_mova: assert property (p_mova) else $error("move to accumulator wrong");
    property p_unsup; ex && !known |=>
        o_unsupported && $stable(o_acc) && $stable(o_zero) && !o_file_wr.we; endproperty
    a_unsup: assert property (p_unsup) else $error("unknown word not idle");
    property p_raddr; i_instr_valid |-> o_file_raddr == i_instr[ADDR_W-1:0]; endproperty
    a_raddr: assert property (p_raddr) else $error("read address wrong");
endmodule : bca_core_checker
bind bca_core bca_core_checker #(.ADDR_W(ADDR_W), .PC_W(PC_W)) bca_core_checker_inst (
    .i_mclk        (i_mclk),
    .i_resetn      (i_resetn),
    .i_instr_valid (i_instr_valid),
    .i_instr       (i_instr),
    .i_file_rdata  (i_file_rdata),
    .o_file_raddr  (o_file_raddr),
    .o_file_wr     (o_file_wr),
    .o_acc         (o_acc),
    .o_zero        (o_zero),
    .o_pc          (o_pc),
    .o_squash      (o_squash),
    .o_unsupported (o_unsupported)
);
`default_nettype wire

// ==== testbench/bca_core_tb.sv ====
// Directed testbench for the execute slice
`timescale 1ns/1ns
`default_nettype none
`include "bca_cfg.svh"
module bca_core_tb
    import bca_pkg::*;
;
    logic i_mclk = 0, i_resetn = 0, i_instr_valid = 0, o_zero, o_squash, o_unsupported;
    logic [11:0] i_instr = 12'h000;
    logic [7:0]  i_file_rdata = 8'h00, o_acc;
    logic [4:0]  o_file_raddr;
    logic [10:0] o_pc, pc0;
    bca_file_wr_t o_file_wr;
    int n_errors = 0, n_compared = 0;
    bca_core bca_core_inst (
        .i_mclk        (i_mclk),
        .i_resetn      (i_resetn),
        .i_instr_valid (i_instr_valid),
        .i_instr       (i_instr),
        .i_file_rdata  (i_file_rdata),
        .o_file_raddr  (o_file_raddr),
        .o_file_wr     (o_file_wr),
        .o_acc         (o_acc),
        .o_zero        (o_zero),
        .o_pc          (o_pc),
        .o_squash      (o_squash),
        .o_unsupported (o_unsupported)
    );
    initial forever #4 i_mclk = ~i_mclk;
    task automatic close_out();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // One valid cycle, then idle so the word runs once
    task automatic ex(input logic [11:0] w, input logic [7:0] r);
        @(posedge i_mclk);
        i_instr_valid <= 1'b1;
        i_instr       <= w;
        i_file_rdata  <= r;
        @(posedge i_mclk);
        i_instr_valid <= 1'b0;
        i_file_rdata  <= ~r;
        #1;
    endtask : ex
    task automatic t_lit();
        ex(`BCA_OPC_LOAD_LIT | 12'h000, 8'h00); chk({o_acc, 7'h00, o_zero}, 16'h0000);
        ex(`BCA_OPC_OR_LIT | 12'h000, 8'h00); chk({o_acc, 7'h00, o_zero}, 16'h0001);
        ex(`BCA_OPC_OR_LIT | 12'h0a0, 8'h00); chk({o_acc, 7'h00, o_zero}, 16'ha000);
    endtask : t_lit
    task automatic t_inc();
        ex(`BCA_OPC_INC_REG | 12'h003, 8'hff); chk({o_acc, 7'h00, o_zero}, 16'h0001);
        ex(`BCA_OPC_INC_REG | 12'h027, 8'h7f); chk({1'b0, o_file_wr, o_zero}, 16'h4f00);
        chk({11'h000, o_file_raddr}, 16'h0007);
    endtask : t_inc
    task automatic t_skip();
        ex(`BCA_OPC_LOAD_LIT | 12'h011, 8'h00);
        pc0 = o_pc;
        ex(`BCA_OPC_INC_SKIP | 12'h003, 8'hff); chk({o_acc, 6'h00, o_squash, o_zero}, 16'h0002);
        ex(`BCA_OPC_LOAD_LIT | 12'h055, 8'h00); chk({o_acc, 7'h00, o_squash}, 16'h0000);
        chk({5'h00, o_pc}, {5'h00, pc0 + 11'h002});
        ex(`BCA_OPC_INC_SKIP | 12'h003, 8'h10); chk({o_acc, 7'h00, o_squash}, 16'h1100);
    endtask : t_skip
    task automatic t_move();
        ex(`BCA_OPC_COPY | 12'h009, 8'h00); chk({2'h0, o_file_wr}, 16'h2911);
        ex(`BCA_OPC_MOVE_REG | 12'h025, 8'h00); chk({o_file_wr, o_zero, o_acc[0]}, 16'h9403);
        ex(`BCA_OPC_MOVE_REG | 12'h005, 8'h3c); chk({o_acc, 7'h00, o_zero}, 16'h3c00);
    endtask : t_move
    task automatic t_or_nop();
        ex(`BCA_OPC_OR_REG | 12'h002, 8'h03); chk({o_acc, 7'h00, o_zero}, 16'h3f00);
        ex(`BCA_OPC_OR_REG | 12'h022, 8'h40); chk({2'h0, o_file_wr}, 16'h227f);
        pc0 = o_pc;
        ex(`BCA_OPC_NOP, 8'h00); chk({o_acc, o_pc[7:0]}, {8'h3f, pc0[7:0] + 8'h01});
        ex(12'h040, 8'h00); chk({o_acc, 7'h00, o_unsupported}, 16'h3f01);
    endtask : t_or_nop
    initial begin
        #100000;
        n_errors++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge i_mclk);
        i_resetn <= 1'b1;
        t_lit();
        t_inc();
        t_skip();
        t_move();
        t_or_nop();
        close_out();
    end
endmodule : bca_core_tb
`default_nettype wire
